// ===== hw/fspp_top.v
// receive frame alignment, signal loss, pointer handling and register slave
// How it works
// - expect framing pattern every 150,520 octets
// - forward aligned octets only while frame locked
// - match bit subsets; raise and clear subsets differ
// - reset drops lock and raises fault
// - raise fault when search exceeds 625 us
// - raise fault after four consecutive missed patterns
// - miss subset small enough for rare faults
// - clear fault after two consecutive clean patterns
// - drop lock after 3 ms continuous fault
// - lock after eight clean patterns past fault
// - integration timer accumulates fault, resets after 3 ms
// - integration: drop at 3 ms, restore after 3 ms
// - flag signal absence on long all-zeros input
// - clear absence after two clean patterns, no zeros
// - transmit normal flag 0110 with pointer
// - positive stuff: invert increment bits, then plus one
// - negative stuff: invert decrement bits, then minus one
// - new alignment: flag 1001 in first frame only
// - no stuff for three frames after any change
// - accept new pointer without flag 1001 only after three repeats
// - mark H3 octets as stuff except on decrement, and the octets after H3 on increment
// - flag 1001 replaces offset at once
`include "fspp_defs.vh"
module fspp_top #(
  parameter [15:0] SEARCH_CYC = `FSPP_SEARCH_CYC,
  parameter [15:0] HOLD_CYC = `FSPP_HOLD_CYC,
  parameter [17:0] FRAME_OCTETS = `FSPP_FRAME_OCTETS,
  parameter [7:0] ZERO_WORDS = `FSPP_ZERO_WORDS
)(
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire rx_word_clk,
  input wire [15:0] rx_word,
  output reg out_valid,
  output reg [7:0] out_octet,
  output reg out_frame_start,
  output reg out_stuff,
  input wire tx_frame_tick,
  output wire [7:0] tx_h1,
  output wire [7:0] tx_h2,
  output wire tx_h3_payload,
  output wire tx_pos_stuff,
  output reg frame_fault,
  output reg frame_locked,
  output reg signal_absent
);
  localparam ST_SEARCH = 1'b0;
  localparam ST_TRACK = 1'b1;
  localparam [31:0] PATTERN = {`FSPP_FIRST_OCTET, `FSPP_FIRST_OCTET,
                               `FSPP_SECOND_OCTET, `FSPP_SECOND_OCTET};

  // link word clock and data come from another domain
  reg wclk_s1;
  reg wclk_s2;
  reg wclk_s3;
  reg [15:0] wdat_s1;
  reg [15:0] wdat_s2;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wclk_s1 <= 1'b0;
      wclk_s2 <= 1'b0;
      wclk_s3 <= 1'b0;
      wdat_s1 <= 16'h0000;
      wdat_s2 <= 16'h0000;
    end else if (ce) begin
      wclk_s1 <= rx_word_clk;
      wclk_s2 <= wclk_s1;
      wclk_s3 <= wclk_s2;
      wdat_s1 <= rx_word;
      wdat_s2 <= wdat_s1;
    end
  end
  // take data on the falling link edge, half a period away from its change
  wire word_stb = wclk_s3 & ~wclk_s2;

  reg [31:0] hist_reg;
  wire [47:0] win = {hist_reg, wdat_s2};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_reg <= 32'h00000000;
    end else if (ce && word_stb) begin
      hist_reg <= {hist_reg[15:0], wdat_s2};
    end
  end

  // full pattern clears the fault; a 16-bit subset decides a miss
  // the short subset keeps random-error misses rare at high error rates
  wire [15:0] hit_full;
  wire [15:0] hit_part;
  genvar gk;
  generate
    for (gk = 0; gk < 16; gk = gk + 1) begin : g_cmp
      wire [31:0] seg = win[47 - gk -: 32];
      assign hit_full[gk] = (seg == PATTERN);
      assign hit_part[gk] = (((seg ^ PATTERN) & `FSPP_MISS_MASK) == 32'h00000000);
    end
  endgenerate

  reg srch_hit;
  reg [3:0] srch_k;
  integer i;
  always @* begin
    srch_hit = 1'b0;
    srch_k = 4'h0;
    for (i = 15; i >= 0; i = i - 1) begin
      if (hit_full[i]) begin
        srch_hit = 1'b1;
        srch_k = i[3:0];
      end
    end
  end

  reg state_reg;
  reg [3:0] off_reg;
  reg [17:0] pos_reg;
  reg [15:0] srch_tmr;
  reg [1:0] good_reg;
  reg [2:0] miss_reg;
  wire [47:0] win_sh = win << off_reg;
  wire [15:0] aligned = win_sh[47:32];
  wire [17:0] pos_nx = (pos_reg >= FRAME_OCTETS - 18'h00002) ?
                       pos_reg + 18'h00002 - FRAME_OCTETS : pos_reg + 18'h00002;
  wire exp_here = word_stb && state_reg == ST_TRACK && pos_nx == `FSPP_PAT_OCTET;
  wire full_at = hit_full[off_reg];
  wire part_at = hit_part[off_reg];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_SEARCH;
      off_reg <= 4'h0;
      pos_reg <= 18'h00000;
      srch_tmr <= 16'h0000;
      good_reg <= 2'h0;
      miss_reg <= 3'h0;
      frame_fault <= 1'b1;
    end else if (ce) begin
      case (state_reg)
        ST_SEARCH: begin
          if (srch_tmr == SEARCH_CYC - 16'h0001) begin
            srch_tmr <= 16'h0000;
            frame_fault <= 1'b1;
          end else begin
            srch_tmr <= srch_tmr + 16'h0001;
          end
          if (word_stb && srch_hit) begin
            state_reg <= ST_TRACK;
            off_reg <= srch_k;
            pos_reg <= `FSPP_PAT_OCTET;
            good_reg <= 2'h1;
            miss_reg <= 3'h0;
          end
        end
        ST_TRACK: begin
          srch_tmr <= 16'h0000;
          if (word_stb) begin
            pos_reg <= pos_nx;
          end
          if (exp_here) begin
            if (full_at) begin
              miss_reg <= 3'h0;
              if (good_reg != 2'h3) begin
                good_reg <= good_reg + 2'h1;
              end
              if (good_reg != 2'h0) begin
                frame_fault <= 1'b0;
              end
            end else if (part_at) begin
              miss_reg <= 3'h0;
              good_reg <= 2'h0;
            end else begin
              good_reg <= 2'h0;
              miss_reg <= miss_reg + 3'h1;
              if (miss_reg == `FSPP_MISS_LIMIT - 3'h1) begin
                frame_fault <= 1'b1;
                state_reg <= ST_SEARCH;
              end
            end
          end
        end
        default: begin
          state_reg <= ST_SEARCH;
        end
      endcase
    end
  end

  // lock control, plain and integrating variants
  reg integ_en_reg;
  reg [3:0] lockg_reg;
  reg [15:0] fault_run;
  reg [15:0] clear_run;
  reg [15:0] integ_reg;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lockg_reg <= 4'h0;
      fault_run <= 16'h0000;
      clear_run <= 16'h0000;
      integ_reg <= 16'h0000;
      frame_locked <= 1'b0;
    end else if (ce) begin
      if (frame_fault) begin
        lockg_reg <= 4'h0;
      end else if (exp_here) begin
        if (!full_at) begin
          lockg_reg <= 4'h0;
        end else if (lockg_reg != `FSPP_LOCK_GOOD) begin
          lockg_reg <= lockg_reg + 4'h1;
        end
      end
      fault_run <= !frame_fault ? 16'h0000 :
                   (fault_run == HOLD_CYC) ? fault_run : fault_run + 16'h0001;
      clear_run <= frame_fault ? 16'h0000 :
                   (clear_run == HOLD_CYC) ? clear_run : clear_run + 16'h0001;
      if (!frame_fault && clear_run == HOLD_CYC) begin
        integ_reg <= 16'h0000;
      end else if (frame_fault && integ_reg != HOLD_CYC) begin
        integ_reg <= integ_reg + 16'h0001;
      end
      if (integ_en_reg) begin
        if (frame_locked && integ_reg == HOLD_CYC) begin
          frame_locked <= 1'b0;
        end else if (!frame_locked && clear_run == HOLD_CYC) begin
          frame_locked <= 1'b1;
        end
      end else begin
        if (frame_locked && fault_run == HOLD_CYC) begin
          frame_locked <= 1'b0;
        end else if (!frame_locked && !frame_fault && lockg_reg == `FSPP_LOCK_GOOD) begin
          frame_locked <= 1'b1;
        end
      end
    end
  end

  // signal absence from a run of all-zeros words
  reg [7:0] zero_run;
  reg [1:0] los_good;
  wire zero_word = word_stb && wdat_s2 == 16'h0000;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zero_run <= 8'h00;
      los_good <= 2'h0;
      signal_absent <= 1'b0;
    end else if (ce) begin
      if (zero_word) begin
        los_good <= 2'h0;
        if (zero_run != ZERO_WORDS) begin
          zero_run <= zero_run + 8'h01;
        end
        if (zero_run == ZERO_WORDS - 8'h01) begin
          signal_absent <= 1'b1;
        end
      end else if (word_stb) begin
        zero_run <= 8'h00;
      end
      if (exp_here && !zero_word) begin
        if (!full_at) begin
          los_good <= 2'h0;
        end else begin
          los_good <= (los_good == 2'h2) ? los_good : los_good + 2'h1;
          if (los_good != 2'h0) begin
            signal_absent <= 1'b0;
          end
        end
      end
    end
  end

  // octet emission: each word gives two octets on consecutive cycles
  reg [15:0] em_word;
  reg [17:0] em_pos;
  reg [1:0] em_cnt;
  wire [7:0] oct_now = (em_cnt == 2'h2) ? em_word[15:8] : em_word[7:0];
  wire [17:0] pos_now = (em_cnt == 2'h2) ? em_pos : em_pos + 18'h00001;
  wire em_act = (em_cnt != 2'h0);
  reg inc_frm;
  reg dec_frm;
  wire in_h3 = pos_now >= `FSPP_PTR_ACT_POS && pos_now < `FSPP_PTR_ACT_END;
  wire in_ps = pos_now >= `FSPP_PTR_ACT_END && pos_now < `FSPP_PSTUFF_END;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      em_word <= 16'h0000;
      em_pos <= 18'h00000;
      em_cnt <= 2'h0;
      out_valid <= 1'b0;
      out_octet <= 8'h00;
      out_frame_start <= 1'b0;
      out_stuff <= 1'b0;
    end else if (ce) begin
      if (word_stb && state_reg == ST_TRACK && frame_locked) begin
        em_word <= aligned;
        em_pos <= pos_nx;
        em_cnt <= 2'h2;
      end else if (em_act) begin
        em_cnt <= em_cnt - 2'h1;
      end
      out_valid <= em_act && frame_locked;
      if (em_act) begin
        out_octet <= oct_now;
        out_frame_start <= (pos_now == 18'h00000);
        out_stuff <= in_h3 ? ~dec_frm : (in_ps & inc_frm);
      end
    end
  end

  // receive pointer interpretation
  reg [7:0] ptr_hi_reg;
  reg [9:0] rx_off;
  reg [9:0] cand_reg;
  reg [1:0] cand_cnt;
  wire [3:0] flag_bits = ptr_hi_reg[7:4];
  wire [9:0] pv = {ptr_hi_reg[1:0], oct_now};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_hi_reg <= 8'h00;
      rx_off <= 10'h000;
      cand_reg <= 10'h000;
      cand_cnt <= 2'h0;
      inc_frm <= 1'b0;
      dec_frm <= 1'b0;
    end else if (ce && em_act) begin
      if (pos_now == 18'h00000) begin
        inc_frm <= 1'b0;
        dec_frm <= 1'b0;
      end
      if (pos_now == `FSPP_PTR_HIGH_POS) begin
        ptr_hi_reg <= oct_now;
      end
      if (pos_now == `FSPP_PTR_LOW_POS) begin
        if (flag_bits == `FSPP_FLAG_SET) begin
          rx_off <= pv;
          cand_cnt <= 2'h0;
        end else if (flag_bits == `FSPP_FLAG_NORM && pv == (rx_off ^ `FSPP_I_MASK)) begin
          rx_off <= (rx_off == `FSPP_PTR_MAX) ? 10'h000 : rx_off + 10'h001;
          inc_frm <= 1'b1;
          cand_cnt <= 2'h0;
        end else if (flag_bits == `FSPP_FLAG_NORM && pv == (rx_off ^ `FSPP_D_MASK)) begin
          rx_off <= (rx_off == 10'h000) ? `FSPP_PTR_MAX : rx_off - 10'h001;
          dec_frm <= 1'b1;
          cand_cnt <= 2'h0;
        end else if (pv != rx_off) begin
          if (pv == cand_reg && cand_cnt == `FSPP_RX_REPEAT - 2'h1) begin
            rx_off <= pv;
            cand_cnt <= 2'h0;
          end else if (pv == cand_reg && cand_cnt != 2'h0) begin
            cand_cnt <= cand_cnt + 2'h1;
          end else begin
            cand_reg <= pv;
            cand_cnt <= 2'h1;
          end
        end else begin
          cand_cnt <= 2'h0;
        end
      end
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  reg dph_wr;
  reg [31:0] dph_addr;
  wire ap_take = hsel && hready && htrans[1];
  wire tx_busy;
  wire [9:0] tx_ptr;
  wire wr_tx = dph_wr && dph_addr == `FSPP_TXCMD_OFS;
  reg [31:0] rd_val;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always @* begin
    rd_val = 32'h00000000;
    case (haddr)
      `FSPP_CTRL_OFS: rd_val[`FSPP_CTRL_INTEG_BIT] = integ_en_reg;
      `FSPP_STATUS_OFS: begin
        rd_val[`FSPP_ST_FAULT_BIT] = frame_fault;
        rd_val[`FSPP_ST_LOCK_BIT] = frame_locked;
        rd_val[`FSPP_ST_ABSENT_BIT] = signal_absent;
      end
      `FSPP_TXCMD_OFS: begin
        rd_val[0] = tx_busy;
        rd_val[`FSPP_PTR_LSB +: 10] = tx_ptr;
      end
      `FSPP_RXPTR_OFS: rd_val[`FSPP_PTR_LSB +: 10] = rx_off;
      default: rd_val = 32'h00000000;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr <= 1'b0;
      dph_addr <= 32'h00000000;
      hrdata <= 32'h00000000;
      integ_en_reg <= `FSPP_CTRL_INTEG_RESET;
    end else if (ce) begin
      if (hready) begin
        dph_wr <= ap_take && hwrite;
        dph_addr <= haddr;
        hrdata <= (ap_take && !hwrite) ? rd_val : 32'h00000000;
      end
      if (dph_wr && dph_addr == `FSPP_CTRL_OFS) begin
        integ_en_reg <= hwdata[`FSPP_CTRL_INTEG_BIT];
      end
    end
  end

  fspp_ptr_gen u_ptr_gen (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .frame_tick(tx_frame_tick),
    .inc_req(wr_tx && hwdata[`FSPP_TX_INC_BIT]),
    .dec_req(wr_tx && hwdata[`FSPP_TX_DEC_BIT]),
    .set_req(wr_tx && hwdata[`FSPP_TX_SET_BIT]),
    .set_val(hwdata[`FSPP_PTR_LSB +: 10]),
    .busy(tx_busy),
    .ptr_cur(tx_ptr),
    .h1_reg(tx_h1),
    .h2_reg(tx_h2),
    .h3_payload_reg(tx_h3_payload),
    .pos_stuff_reg(tx_pos_stuff)
  );
endmodule

// ===== hw/fspp_defs.vh
// shared constants for the frame sync and pointer processor
`ifndef FSPP_DEFS_VH
`define FSPP_DEFS_VH

// clock rate and times, each time in its own unit
`define FSPP_CLK_MHZ 10
`define FSPP_SEARCH_US 625
// cycle counts at the clock above, sized to the timer width
`define FSPP_SEARCH_CYC 16'h186A
`define FSPP_HOLD_US 3000
`define FSPP_HOLD_CYC 16'h7530

// frame geometry, octet positions within one frame
`define FSPP_FRAME_OCTETS 18'h24BF8
`define FSPP_PAT_OCTET 18'h000BE
`define FSPP_PTR_HIGH_POS 18'h0CA80
`define FSPP_PTR_LOW_POS 18'h0CB40
`define FSPP_PTR_ACT_POS 18'h0CC00
`define FSPP_PTR_ACT_END 18'h0CCC0
`define FSPP_PSTUFF_END 18'h0CD80

// framing octets, the miss subset mask, and the miss, lock and zero-run counts
`define FSPP_FIRST_OCTET 8'hF6
`define FSPP_SECOND_OCTET 8'h28
`define FSPP_MISS_MASK 32'h0000FFFF
`define FSPP_MISS_LIMIT 3'h4
`define FSPP_LOCK_GOOD 4'h8
`define FSPP_ZERO_WORDS 8'h40

// pointer coding
`define FSPP_FLAG_NORM 4'h6
`define FSPP_FLAG_SET 4'h9
`define FSPP_I_MASK 10'h2AA
`define FSPP_D_MASK 10'h155
`define FSPP_PTR_MAX 10'h30E
`define FSPP_TX_HOLD 2'h3
`define FSPP_RX_REPEAT 2'h3

// register offsets and fields
`define FSPP_CTRL_OFS 32'h00000000
`define FSPP_STATUS_OFS 32'h00000004
`define FSPP_TXCMD_OFS 32'h00000008
`define FSPP_RXPTR_OFS 32'h0000000C
`define FSPP_CTRL_INTEG_BIT 0
`define FSPP_ST_FAULT_BIT 0
`define FSPP_ST_LOCK_BIT 1
`define FSPP_ST_ABSENT_BIT 2
`define FSPP_TX_INC_BIT 0
`define FSPP_TX_DEC_BIT 1
`define FSPP_TX_SET_BIT 2
`define FSPP_PTR_LSB 16
`define FSPP_CTRL_RESET 32'h00000000
`define FSPP_CTRL_INTEG_RESET 1'b0

`endif

// ===== hw/fspp_ptr_gen.v
// transmit payload pointer generator, one pointer word per frame
`include "fspp_defs.vh"
module fspp_ptr_gen (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire frame_tick,
  input wire inc_req,
  input wire dec_req,
  input wire set_req,
  input wire [9:0] set_val,
  output wire busy,
  output wire [9:0] ptr_cur,
  output reg [7:0] h1_reg,
  output reg [7:0] h2_reg,
  output reg h3_payload_reg,
  output reg pos_stuff_reg
);
  reg [9:0] ptr_reg;
  reg [9:0] sv_reg;
  reg inc_pend_reg;
  reg dec_pend_reg;
  reg set_pend_reg;
  reg [1:0] hold_reg;
  wire [9:0] inc_code = ptr_reg ^ `FSPP_I_MASK;
  wire [9:0] dec_code = ptr_reg ^ `FSPP_D_MASK;

  assign busy = set_pend_reg | inc_pend_reg | dec_pend_reg;
  assign ptr_cur = ptr_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_reg <= 10'h000;
      sv_reg <= 10'h000;
      inc_pend_reg <= 1'b0;
      dec_pend_reg <= 1'b0;
      set_pend_reg <= 1'b0;
      hold_reg <= 2'h0;
      h1_reg <= {`FSPP_FLAG_NORM, 4'h0};
      h2_reg <= 8'h00;
      h3_payload_reg <= 1'b0;
      pos_stuff_reg <= 1'b0;
    end else if (ce) begin
      if (frame_tick) begin
        h3_payload_reg <= 1'b0;
        pos_stuff_reg <= 1'b0;
        if (set_pend_reg) begin
          // flag 1001 only in the first frame with the new value
          h1_reg <= {`FSPP_FLAG_SET, 2'b00, sv_reg[9:8]};
          h2_reg <= sv_reg[7:0];
          ptr_reg <= sv_reg;
          set_pend_reg <= 1'b0;
          hold_reg <= `FSPP_TX_HOLD;
        end else if (inc_pend_reg && hold_reg == 2'h0) begin
          h1_reg <= {`FSPP_FLAG_NORM, 2'b00, inc_code[9:8]};
          h2_reg <= inc_code[7:0];
          pos_stuff_reg <= 1'b1;
          ptr_reg <= (ptr_reg == `FSPP_PTR_MAX) ? 10'h000 : ptr_reg + 10'h001;
          inc_pend_reg <= 1'b0;
          hold_reg <= `FSPP_TX_HOLD;
        end else if (dec_pend_reg && hold_reg == 2'h0) begin
          h1_reg <= {`FSPP_FLAG_NORM, 2'b00, dec_code[9:8]};
          h2_reg <= dec_code[7:0];
          h3_payload_reg <= 1'b1;
          ptr_reg <= (ptr_reg == 10'h000) ? `FSPP_PTR_MAX : ptr_reg - 10'h001;
          dec_pend_reg <= 1'b0;
          hold_reg <= `FSPP_TX_HOLD;
        end else begin
          h1_reg <= {`FSPP_FLAG_NORM, 2'b00, ptr_reg[9:8]};
          h2_reg <= ptr_reg[7:0];
          if (hold_reg != 2'h0) begin
            hold_reg <= hold_reg - 2'h1;
          end
        end
      end
      // requests while the same kind is pending are dropped
      if (set_req && !set_pend_reg) begin
        set_pend_reg <= 1'b1;
        sv_reg <= set_val;
      end
      if (inc_req && !inc_pend_reg && !dec_pend_reg) begin
        inc_pend_reg <= 1'b1;
      end
      if (dec_req && !dec_pend_reg && !inc_pend_reg && !inc_req) begin
        dec_pend_reg <= 1'b1;
      end
    end
  end
endmodule

// ===== verification/fspp_link_model.sv
// far-side line model: free-running word clock and a framed word stream
module fspp_link_model #(
  parameter int WORDS = 128
) (
  output logic rx_word_clk,
  output logic [15:0] rx_word,
  input wire logic [1:0] mode
);
  timeunit 1ns;
  timeprecision 1ns;
  int w = 0;
  // mode 0 clean frames, 1 framing words spoilt, 2 all-zeros line
  initial begin
    rx_word_clk = 1'b0;
    rx_word = 16'h0001;
    #137;
    forever begin
      #400 rx_word_clk = 1'b1;
      w = (w + 1) % WORDS;
      if (mode == 2'h2) begin
        rx_word = 16'h0000;
      end else if (w == 95) begin
        rx_word = (mode == 2'h1) ? 16'h1111 : 16'hF6F6;
      end else if (w == 96) begin
        rx_word = (mode == 2'h1) ? 16'h1111 : 16'h2828;
      end else begin
        rx_word = {w[6:0], 1'b0, w[6:0], 1'b1};
      end
      #400 rx_word_clk = 1'b0;
    end
  end
endmodule

// ===== verification/fspp_chk_assertions.sv
// checker for alignment status, forwarding and transmit pointer outputs
module fspp_chk #(
  parameter [15:0] HOLD_CYC = 16'h7530
) (
  input wire hclk,
  input wire hresetn,
  input wire [15:0] rx_word,
  input wire out_valid,
  input wire frame_fault,
  input wire frame_locked,
  input wire signal_absent,
  input wire tx_frame_tick,
  input wire [7:0] tx_h1,
  input wire [7:0] tx_h2,
  input wire tx_h3_payload,
  input wire tx_pos_stuff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [16:0] fault_run;
  wire [9:0] ptr_seen = {tx_h1[1:0], tx_h2};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_run <= 17'h00000;
    end else if (!frame_fault) begin
      fault_run <= 17'h00000;
    end else if (fault_run != 17'h1FFFF) begin
      fault_run <= fault_run + 17'h00001;
    end
  end
  // one cycle of slack: lock and octet outputs are separate registers
  data_when_locked_a: assert property (out_valid |-> frame_locked || $past(frame_locked))
    else $error("octet forwarded without lock");
  reset_state_a: assert property ($rose(hresetn) |-> frame_fault && !frame_locked)
    else $error("wrong state after reset");
  fault_hold_a: assert property (fault_run > {1'b0, HOLD_CYC} + 17'h00008 |-> !frame_locked)
    else $error("lock kept through long fault");
  lock_after_clear_a: assert property ($rose(frame_locked) |-> !$past(frame_fault, 8))
    else $error("lock without clean patterns");
  absent_zero_a: assert property ($rose(signal_absent) |-> rx_word == 16'h0000)
    else $error("absence flagged on live line");
  tx_flag_a: assert property (tx_h1[7:2] == 6'h18 || tx_h1[7:2] == 6'h24)
    else $error("bad flag field");
  set_once_a: assert property (tx_frame_tick && tx_h1[7:4] == 4'h9 |-> ##1 tx_h1[7:4] == 4'h6)
    else $error("set flag kept past one frame");
  // a set request may overtake the step; the top value wraps
  pos_stuff_a: assert property (tx_frame_tick && tx_pos_stuff |-> ##1
    (tx_h1[7:4] != 4'h6 || $past(ptr_seen ^ 10'h2AA) == 10'h30E ||
    ptr_seen == ($past(ptr_seen) ^ 10'h2AA) + 10'h001))
    else $error("pointer not stepped up after positive stuff");
  neg_stuff_a: assert property (tx_frame_tick && tx_h3_payload |-> ##1
    (tx_h1[7:4] != 4'h6 || $past(ptr_seen ^ 10'h155) == 10'h000 ||
    ptr_seen == ($past(ptr_seen) ^ 10'h155) - 10'h001))
    else $error("pointer not stepped down after negative stuff");
  ptr_steady_a: assert property ($changed(tx_h1) || $changed(tx_h2) |-> $past(tx_frame_tick))
    else $error("pointer changed between frames");
endmodule
bind fspp_top fspp_chk #(.HOLD_CYC(HOLD_CYC)) i_fspp_chk (.hclk, .hresetn, .rx_word, .out_valid,
  .frame_fault, .frame_locked, .signal_absent, .tx_frame_tick, .tx_h1, .tx_h2,
  .tx_h3_payload, .tx_pos_stuff);

// ===== verification/tb.sv
// self-checking bench: alignment, lock, signal loss, pointer words, registers
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FRAME_CYC = 1024;
  localparam logic [15:0] HOLD = 16'h2000;
  logic hclk, hresetn, hsel, hwrite, tick, hreadyout, hresp, rx_word_clk;
  logic out_valid, out_frame_start, out_stuff, tx_h3_payload, tx_pos_stuff;
  logic frame_fault, frame_locked, signal_absent;
  logic [1:0] htrans, mode;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] rx_word;
  logic [7:0] out_octet, tx_h1, tx_h2;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  fspp_top #(.SEARCH_CYC(16'h1400), .HOLD_CYC(HOLD), .FRAME_OCTETS(18'h00100)) i_fspp_top (
    .hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_word_clk, .rx_word, .out_valid,
    .out_octet, .out_frame_start, .out_stuff, .tx_frame_tick(tick), .tx_h1, .tx_h2,
    .tx_h3_payload, .tx_pos_stuff, .frame_fault, .frame_locked, .signal_absent);
  fspp_link_model #(.WORDS(128)) i_fspp_link_model (.rx_word_clk, .rx_word, .mode);
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles = cycles + 1;
    if (cycles == 90000) begin
      bad_count = bad_count + 1;
      print_verdict();
    end
  end
  task print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // bounded wait for a level; running out counts as a mismatch
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge hclk);
      n++;
    end
    check(s, v, "level wait");
  endtask
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(hresp, 1'b0, "bus response");
  endtask
  // mode changes at frame start, well away from the framing words
  task burst(input logic [1:0] m, input int frames);
    wait_lvl(out_frame_start, 1'b1, 2 * FRAME_CYC);
    mode <= m;
    repeat (frames * FRAME_CYC) @(posedge hclk);
  endtask
  task tx_frame(input logic [31:0] exp);
    @(posedge hclk);
    tick <= 1'b1;
    @(posedge hclk);
    tick <= 1'b0;
    @(posedge hclk);
    check({14'h0000, tx_pos_stuff, tx_h3_payload, tx_h1, tx_h2}, exp, "tx pointer word");
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    tick = 1'b0;
    htrans = 2'h0;
    mode = 2'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    check({frame_fault, frame_locked, signal_absent}, 3'h4, "status after reset");
    check({tx_h1, tx_h2}, 16'h6000, "tx word after reset");
    ahb(1'b0, 32'h00000004, 32'h00000000);
    check(rd, 32'h00000001, "status register");
    ahb(1'b1, 32'h00000000, 32'h00000001);
    ahb(1'b0, 32'h00000000, 32'h00000000);
    check(rd, 32'h00000001, "control readback");
    ahb(1'b1, 32'h00000000, 32'h00000000);
    ahb(1'b1, 32'h00000010, 32'hFFFFFFFF);
    ahb(1'b0, 32'h00000010, 32'h00000000);
    check(rd, 32'h00000000, "unmapped read");
    wait_lvl(frame_fault, 1'b0, 4 * FRAME_CYC);
    wait_lvl(frame_locked, 1'b1, 25 * FRAME_CYC);
    check(n >= 7 * FRAME_CYC, 1'b1, "lock too early");
    wait_lvl(out_frame_start, 1'b1, 2 * FRAME_CYC);
    check({out_valid, out_stuff, out_octet}, 10'h200, "first octet of frame");
    burst(2'h1, 3);
    mode <= 2'h0;
    repeat (2 * FRAME_CYC) @(posedge hclk);
    check({frame_fault, frame_locked}, 2'h1, "three misses");
    burst(2'h1, 4);
    mode <= 2'h0;
    check(frame_fault, 1'b1, "four misses");
    wait_lvl(frame_fault, 1'b0, 3 * FRAME_CYC);
    check({n > FRAME_CYC, frame_locked}, 2'h3, "clear after two patterns");
    burst(2'h1, 0);
    wait_lvl(frame_locked, 1'b0, HOLD + 6 * FRAME_CYC);
    check(n >= HOLD + 3 * FRAME_CYC, 1'b1, "lock dropped early");
    check(frame_fault, 1'b1, "fault while searching");
    mode <= 2'h2;
    wait_lvl(signal_absent, 1'b1, 1000);
    mode <= 2'h0;
    wait_lvl(signal_absent, 1'b0, 4 * FRAME_CYC);
    check(n >= FRAME_CYC - 40, 1'b1, "absence cleared early");
    wait_lvl(frame_locked, 1'b1, 12 * FRAME_CYC);
    ahb(1'b1, 32'h00000008, 32'h00000001);
    tx_frame(32'h000262AA);
    ahb(1'b1, 32'h00000008, 32'h00000002);
    tx_frame(32'h00006001);
    tx_frame(32'h00006001);
    tx_frame(32'h00006001);
    tx_frame(32'h00016154);
    tx_frame(32'h00006000);
    ahb(1'b1, 32'h00000008, 32'h01230004);
    tx_frame(32'h00009123);
    tx_frame(32'h00006123);
    ahb(1'b0, 32'h00000008, 32'h00000000);
    check(rd, 32'h01230000, "tx pointer readback");
    // integrating lock: drop after accumulated fault, relock after long clear
    ahb(1'b1, 32'h00000000, 32'h00000001);
    burst(2'h1, 0);
    wait_lvl(frame_locked, 1'b0, HOLD + 6 * FRAME_CYC);
    mode <= 2'h0;
    wait_lvl(frame_locked, 1'b1, HOLD + 4 * FRAME_CYC);
    check(n >= HOLD, 1'b1, "integrated relock early");
    print_verdict();
  end
endmodule
